// file: logic/clock_pulse_gen_pkg.sv
package clock_pulse_gen_pkg;

	// register index as printed; the bus byte address is four times it
	localparam logic [17:0] CTRL_INDEX      = 18'h0ff3a;
	localparam logic [17:0] CTRL_BYTE_ADDR  = 18'(CTRL_INDEX * 4);
	localparam logic [7:0]  CTRL_RESET      = 8'h00;
	// bits that software may change: disable, bit 6 and the select field
	localparam logic [7:0]  CTRL_WRITE_MASK = 8'hc7;
	localparam int          PHI_OFF_BIT     = 7;
	localparam int          RSVD_RW_BIT     = 6;
	localparam int          SEL_MSB         = 2;

	// divider geometry: one phi period is two clk_i cycles, slowest tap phi/32
	localparam int          DIV_BITS        = 6;
	localparam logic [5:0]  DIV_WRAP        = 6'h3f;
	localparam logic [4:0]  MED_ALL_HIGH    = 5'h1f;

	// bus-master clock select codes
	localparam logic [2:0]  SEL_FULL        = 3'h0;
	localparam logic [2:0]  SEL_DIV2        = 3'h1;
	localparam logic [2:0]  SEL_DIV32       = 3'h5;

	// clock output pin behaviour
	typedef enum logic [2:0] {
		PIN_CLOCK = 3'b001,
		PIN_HIGH  = 3'b010,
		PIN_FLOAT = 3'b100
	} pin_mode_t;

	// classic wishbone request and answer
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [17:0] adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_t;

endpackage

// file: logic/clock_pulse_gen_divider.sv
`timescale 1ns/1ps

module clock_pulse_gen_divider
	import clock_pulse_gen_pkg::*;
(
	input  wire logic                                  clk_i,
	input  wire logic                                  rst_n_i,
	input  wire logic                                  run_i,
	output logic [clock_pulse_gen_pkg::DIV_BITS-1:0]   cnt_o,
	output logic [clock_pulse_gen_pkg::DIV_BITS-1:0]   wave_o,
	output logic [clock_pulse_gen_pkg::DIV_BITS-1:0]   wave_next_o,
	output logic                                       wrap_next_o
);
	import clock_pulse_gen_pkg::*;

	logic [DIV_BITS-1:0] cnt_reg;    // free phase counter
	logic [DIV_BITS-1:0] cnt_next;
	logic [DIV_BITS-1:0] wave_reg;   // tap waveforms, bit 0 is phi
	logic [DIV_BITS-1:0] wave_next;

	////////////////////////////////////////////////////////////////////////
	// counter advances only while the oscillator runs
	always_comb begin
		cnt_next = cnt_reg;
		if (run_i) begin
			cnt_next = cnt_reg + 6'h01;
		end
	end

	// every tap is the inverted counter bit, so all taps rise together at wrap
	genvar k;
	generate
		for (k = 0; k < DIV_BITS; k = k + 1) begin : g_tap
			assign wave_next[k] = ~cnt_next[k];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// register counter and taps
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg  <= DIV_WRAP;
			wave_reg <= '0;
		end else begin
			cnt_reg  <= cnt_next;
			wave_reg <= wave_next;
		end
	end

	assign cnt_o       = cnt_reg;
	assign wave_o      = wave_reg;
	assign wave_next_o = wave_next;
	assign wrap_next_o = run_i && (cnt_reg == DIV_WRAP);

endmodule // clock_pulse_gen_divider

// file: logic/clock_pulse_gen.sv
// The Wishbone register port was decided locally.
`timescale 1ns/1ps

// Overview of operation
// - control register clears on reset, hardware standby
// - disable clear: pin shows clock when running
// - disable set: pin high, floats in hardware standby
// - bit six stores and reads back
// - bits five to three read zero
// - select zero gives undivided system clock
// - codes one to three give halves to eighths
// - codes four, five give sixteenth, thirty-second
// - system clock duty corrected to even halves
// - divider makes five medium-speed clocks
// - only select field routes clock to master
// - peripherals keep full-speed system clock
module clock_pulse_gen
	import clock_pulse_gen_pkg::*;
(
	input  wire logic                        clk_i,
	input  wire logic                        rst_n_i,
	input  wire clock_pulse_gen_pkg::wb_req_t wb_req_i,
	output clock_pulse_gen_pkg::wb_rsp_t      wb_rsp_o,
	input  wire logic                        sleep_i,
	input  wire logic                        sw_standby_i,
	input  wire logic                        hw_standby_pin_i,
	output logic                             sys_clk_o,
	output logic [4:0]                       med_clk_o,
	output logic                             bm_clk_o,
	output logic [2:0]                       bm_clk_sel_o,
	output logic                             phi_pin_o,
	output logic                             phi_pin_oe_n_o
);
	import clock_pulse_gen_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic [1:0]          hw_sync_reg;      // two-stage synchroniser of the pin
	logic [1:0]          hw_sync_next;
	logic                hw_standby;       // synchronised hardware standby
	logic                run;              // oscillator considered running

	logic [7:0]          sys_clk_ctrl_reg; // software control register
	logic [7:0]          sys_clk_ctrl_next;
	logic [2:0]          sel_active_reg;   // selection actually in force
	logic [2:0]          sel_active_next;

	logic                ack_reg;          // bus answer strobe
	logic                ack_next;
	logic [31:0]         rdat_reg;         // bus read data
	logic [31:0]         rdat_next;
	logic                bus_req;          // live wishbone request
	logic                hit;              // request addresses the register
	logic                wr_take;          // write takes effect this edge

	logic                bm_clk_reg;       // bus-master clock
	logic                bm_clk_next;
	logic                pin_reg;          // pin output level
	logic                pin_next;
	logic                pin_oe_n_reg;     // pin enable, low drives
	logic                pin_oe_n_next;
	pin_mode_t           pin_mode;         // pin behaviour this cycle

	logic [DIV_BITS-1:0] cnt;              // divider phase
	logic [DIV_BITS-1:0] wave;             // registered taps
	logic [DIV_BITS-1:0] wave_next;        // taps one edge ahead
	logic                wrap_next;        // all taps rise at the next edge

	////////////////////////////////////////////////////////////////////////
	// synchroniser for the hardware standby pin
	always_comb begin
		hw_sync_next = {hw_sync_reg[0], hw_standby_pin_i};
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hw_sync_reg <= 2'h0;
		end else begin
			hw_sync_reg <= hw_sync_next;
		end
	end

	assign hw_standby = hw_sync_reg[1];
	// oscillator stops in either standby
	assign run        = !sw_standby_i && !hw_standby;

	////////////////////////////////////////////////////////////////////////
	// medium-speed divider; tap 0 is phi with exactly even halves
	clock_pulse_gen_divider u_divider (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.run_i       (run),
		.cnt_o       (cnt),
		.wave_o      (wave),
		.wave_next_o (wave_next),
		.wrap_next_o (wrap_next)
	);

	////////////////////////////////////////////////////////////////////////
	// wishbone slave decode
	assign bus_req = wb_req_i.cyc && wb_req_i.stb;
	assign hit     = (wb_req_i.adr == CTRL_BYTE_ADDR);
	// write lands on the edge that raises ack
	assign wr_take = bus_req && !ack_reg && wb_req_i.we && hit && wb_req_i.sel[0];

	// next answer and read data
	always_comb begin
		ack_next  = bus_req && !ack_reg;
		rdat_next = 32'h0000_0000;
		if (bus_req && !ack_reg && !wb_req_i.we && hit) begin
			// reserved bits 5..3 are never stored, so they read zero
			rdat_next = {24'h00_0000, sys_clk_ctrl_reg & CTRL_WRITE_MASK};
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_reg  <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			ack_reg  <= ack_next;
			rdat_reg <= rdat_next;
		end
	end

	assign wb_rsp_o.ack = ack_reg;
	assign wb_rsp_o.dat = rdat_reg;

	////////////////////////////////////////////////////////////////////////
	// control register and active selection
	always_comb begin
		sys_clk_ctrl_next = sys_clk_ctrl_reg;
		sel_active_next   = sel_active_reg;
		if (hw_standby) begin
			// hardware standby clears, software standby simply holds
			sys_clk_ctrl_next = CTRL_RESET;
			sel_active_next   = SEL_FULL;
		end else begin
			if (wr_take) begin
				// bit 6 stores, bits 5..3 drop
				sys_clk_ctrl_next = wb_req_i.dat[7:0] & CTRL_WRITE_MASK;
			end
			// a new selection takes over only when all taps rise together
			if (wrap_next && (sys_clk_ctrl_reg[SEL_MSB:0] <= SEL_DIV32)) begin
				sel_active_next = sys_clk_ctrl_reg[SEL_MSB:0];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sys_clk_ctrl_reg <= CTRL_RESET;
			sel_active_reg   <= SEL_FULL;
		end else begin
			sys_clk_ctrl_reg <= sys_clk_ctrl_next;
			sel_active_reg   <= sel_active_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus-master clock: code n picks tap n, code 0 is phi itself
	always_comb begin
		bm_clk_next = wave_next[sel_active_next];
	end

	// pin behaviour per mode
	always_comb begin
		if (hw_standby) begin
			pin_mode = PIN_FLOAT;
		end else if (sw_standby_i || sys_clk_ctrl_reg[PHI_OFF_BIT]) begin
			pin_mode = PIN_HIGH;
		end else begin
			pin_mode = PIN_CLOCK;
		end
	end

	// pin level and enable
	always_comb begin
		pin_next      = 1'b1;
		pin_oe_n_next = 1'b0;
		unique case (pin_mode)
			PIN_CLOCK: begin
				pin_next = wave_next[0];
			end
			PIN_HIGH: begin
				pin_next = 1'b1;
			end
			PIN_FLOAT: begin
				pin_oe_n_next = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bm_clk_reg   <= 1'b0;
			pin_reg      <= 1'b1;
			pin_oe_n_reg <= 1'b0;
		end else begin
			bm_clk_reg   <= bm_clk_next;
			pin_reg      <= pin_next;
			pin_oe_n_reg <= pin_oe_n_next;
		end
	end

	// peripherals always see tap 0, whatever the master uses
	assign sys_clk_o      = wave[0];
	assign med_clk_o      = wave[5:1];
	assign bm_clk_o       = bm_clk_reg;
	assign bm_clk_sel_o   = sel_active_reg;
	assign phi_pin_o      = pin_reg;
	assign phi_pin_oe_n_o = pin_oe_n_reg;

	////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_HW_CLEARS: assert property (hw_standby |=> sys_clk_ctrl_reg == CTRL_RESET)
		else $error("control register not cleared in hardware standby");

	AST_SW_HOLDS: assert property (sw_standby_i && !hw_standby && !wr_take |=> $stable(sys_clk_ctrl_reg))
		else $error("control register changed in software standby");

	// gated by reset so the release edge, where flops still held reset, is not judged
	AST_PIN_CLOCK: assert property (rst_n_i && pin_mode == PIN_CLOCK |=> phi_pin_o == sys_clk_o && !phi_pin_oe_n_o)
		else $error("pin does not follow system clock");

	AST_PIN_HIGH: assert property (sys_clk_ctrl_reg[PHI_OFF_BIT] && !hw_standby |=> phi_pin_o && !phi_pin_oe_n_o)
		else $error("disabled pin not held high");

	AST_PIN_FLOAT: assert property (hw_standby |=> phi_pin_oe_n_o)
		else $error("pin driven in hardware standby");

	AST_BIT6_STORE: assert property (wr_take && !hw_standby |=> sys_clk_ctrl_reg[RSVD_RW_BIT] == $past(wb_req_i.dat[6]))
		else $error("bit six did not store");

	AST_RSVD_ZERO: assert property (ack_reg |-> wb_rsp_o.dat[5:3] == 3'h0)
		else $error("reserved bits read nonzero");

	AST_FULL_SPEED: assert property (sel_active_reg == SEL_FULL |-> bm_clk_o == sys_clk_o)
		else $error("code zero does not give system clock");

	AST_DIV2: assert property (sel_active_reg == SEL_DIV2 |-> bm_clk_o == !cnt[1])
		else $error("code one is not half rate");

	AST_DIV32: assert property (sel_active_reg == SEL_DIV32 |-> bm_clk_o == !cnt[5])
		else $error("code five is not thirty-second rate");

	AST_DUTY: assert property (run && $rose(sys_clk_o) ##1 run |-> !sys_clk_o)
		else $error("system clock high half not one cycle");

	AST_TAPS_ALIGN: assert property (rst_n_i && run && cnt == DIV_WRAP |=> med_clk_o == MED_ALL_HIGH && sys_clk_o)
		else $error("medium clocks not aligned at wrap");

	AST_ROUTE: assert property (bm_clk_o == wave[sel_active_reg])
		else $error("master clock not the selected tap");

	// the first edge after release has no toggle behind it yet
	AST_PERIPH_FULL: assert property (run && $past(run) && $past(rst_n_i) |-> sys_clk_o != $past(sys_clk_o))
		else $error("system clock stalled while running");

	AST_SWITCH_AT_WRAP: assert property ($changed(sel_active_reg) && !hw_standby |-> cnt == 6'h00)
		else $error("selection switched away from wrap");

	AST_NO_ILLEGAL: assert property (sel_active_reg <= SEL_DIV32)
		else $error("illegal selection in force");

	COV_SWITCH: cover property ($changed(sel_active_reg) && sel_active_reg == SEL_DIV32);
	COV_HW: cover property ($rose(hw_standby));
	COV_PIN_OFF: cover property (pin_mode == PIN_HIGH && !sw_standby_i);
	COV_SW: cover property (sw_standby_i && sel_active_reg != SEL_FULL);
	// sleep leaves the pin clocking like normal operation
	COV_SLEEP: cover property (sleep_i && pin_mode == PIN_CLOCK);

endmodule // clock_pulse_gen

// file: tb/clk_period_meter.sv
`timescale 1ns/1ps

// far-side consumer: times the clock it is fed, in clk_i cycles
module clk_period_meter (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       tap_i,
	output logic [7:0]      period_o
);
	logic       last_reg; // previous sample of the tap
	logic [7:0] cnt_reg;  // cycles since the last rising edge

	////////////////////////////////////////////////////////////
	// latch the count at each rising edge of the tap
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			last_reg <= 1'b0;
			cnt_reg <= 8'h00;
			period_o <= 8'h00;
		end else begin
			last_reg <= tap_i;
			cnt_reg <= (tap_i && !last_reg) ? 8'h01 : cnt_reg + 8'h01;
			if (tap_i && !last_reg) begin // rising edge ends a period
				period_o <= cnt_reg;
			end
		end
	end
endmodule // clk_period_meter

// file: tb/tb.sv
`timescale 1ns/1ps

module tb;
	import clock_pulse_gen_pkg::*;

	logic        clk_i = 1'b0;
	logic        rst_n_i;
	wb_req_t     wb_req_i;
	wb_rsp_t     wb_rsp_o;
	logic        sleep_i, sw_standby_i, hw_standby_pin_i;
	logic        sys_clk_o, bm_clk_o, phi_pin_o, phi_pin_oe_n_o;
	logic [4:0]  med_clk_o;
	logic [2:0]  bm_clk_sel_o;
	logic [7:0]  sys_per, bm_per, slow_per; // measured periods
	logic [7:0]  med_per;                   // period of the medium tap under test
	logic [2:0]  med_idx = 3'h0;            // medium tap under test
	logic [7:0]  val;                       // last value written
	logic [31:0] exp_q[$];                  // expected bus answers
	int          bad_count = 0;
	int          samples_checked = 0;
	int          seed = 81;
	localparam logic [17:0] A = CTRL_BYTE_ADDR;

	always #5 clk_i = ~clk_i;

	clock_pulse_gen uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
		.sleep_i(sleep_i), .sw_standby_i(sw_standby_i), .hw_standby_pin_i(hw_standby_pin_i),
		.sys_clk_o(sys_clk_o), .med_clk_o(med_clk_o), .bm_clk_o(bm_clk_o), .bm_clk_sel_o(bm_clk_sel_o),
		.phi_pin_o(phi_pin_o), .phi_pin_oe_n_o(phi_pin_oe_n_o));
	clk_period_meter m_sys (.clk_i(clk_i), .rst_n_i(rst_n_i), .tap_i(sys_clk_o), .period_o(sys_per));
	clk_period_meter m_bm (.clk_i(clk_i), .rst_n_i(rst_n_i), .tap_i(bm_clk_o), .period_o(bm_per));
	clk_period_meter m_slow (.clk_i(clk_i), .rst_n_i(rst_n_i), .tap_i(med_clk_o[4]), .period_o(slow_per));
	clk_period_meter m_med (.clk_i(clk_i), .rst_n_i(rst_n_i), .tap_i(med_clk_o[med_idx]), .period_o(med_per));

	////////////////////////////////////////////////////////////
	// compare and count
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (exp !== got) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			bad_count++;
		end
	endtask

	// closing verdict
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// one classic wishbone cycle; the answer is noted for the monitor
	task automatic wb_cycle(input logic we, input logic [17:0] adr, input logic [3:0] sel,
		input logic [7:0] dat, input logic [7:0] exp);
		int n;
		n = 0;
		exp_q.push_back({24'h0, exp});
		@(posedge clk_i);
		wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: {24'h0, dat}};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_rsp_o.ack !== 1'b1 && n < 100);
		if (n >= 100) check("ack", 32'h1, 32'h0);
		wb_req_i <= '0;
	endtask

	// watch the clock output pin for eight cycles
	task automatic pin_watch(input logic toggles, input logic exp_oe_n);
		logic seen0, seen1;
		seen0 = 1'b0;
		seen1 = 1'b0;
		repeat (3) @(posedge clk_i);
		repeat (8) begin
			@(posedge clk_i);
			if (phi_pin_o === 1'b0) seen0 = 1'b1;
			if (phi_pin_o === 1'b1) seen1 = 1'b1;
		end
		check("pin low seen", {31'h0, toggles}, {31'h0, seen0});
		check("pin high seen", 32'h1, {31'h0, seen1});
		check("pin enable", {31'h0, exp_oe_n}, {31'h0, phi_pin_oe_n_o});
	endtask

	////////////////////////////////////////////////////////////
	// monitor: every ack takes the oldest note
	always @(posedge clk_i) begin
		if (wb_rsp_o.ack === 1'b1 && exp_q.size() > 0) begin
			check("bus data", exp_q.pop_front(), wb_rsp_o.dat);
		end
	end

	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk_i);
		check("timeout", 32'h0, 32'h1);
		wrap_up;
	end

	////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst_n_i = 1'b0;
		wb_req_i = '0;
		sleep_i = 1'b0;
		sw_standby_i = 1'b0;
		hw_standby_pin_i = 1'b0;
		val = 8'h00;
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		wb_cycle(1'b0, A, 4'h1, 8'h00, CTRL_RESET);
		pin_watch(1'b1, 1'b0);
		repeat (140) @(posedge clk_i);
		check("system period", 32'd2, {24'h0, sys_per});
		check("slowest period", 32'd64, {24'h0, slow_per});
		// every legal select code, with random reserved bits
		// codes six and seven are never written by software
		for (int code = 0; code < 6; code++) begin
			val = (8'($random(seed)) & 8'h78) | 8'(code);
			wb_cycle(1'b1, A, 4'h1, val, 8'h00);
			wb_cycle(1'b0, A, 4'h1, 8'h00, val & CTRL_WRITE_MASK);
			if (code > 0) begin
				med_idx = 3'(code - 1);
			end
			for (int n = 0; n < 200 && bm_clk_sel_o !== code[2:0]; n++) @(posedge clk_i);
			check("select", 32'(code), {29'h0, bm_clk_sel_o});
			repeat (140) @(posedge clk_i);
			check("master period", 32'(2 << code), {24'h0, bm_per});
			check("peripheral period", 32'd2, {24'h0, sys_per});
			if (code > 0) begin
				check("medium period", 32'(2 << code), {24'h0, med_per});
			end
		end
		// refused writes: lane 0 off, then an unmapped address
		wb_cycle(1'b1, A, 4'h0, 8'h80, 8'h00);
		wb_cycle(1'b1, A + 18'h4, 4'h1, 8'h80, 8'h00);
		wb_cycle(1'b0, A + 18'h4, 4'h1, 8'h00, 8'h00);
		wb_cycle(1'b0, A, 4'h1, 8'h00, val & CTRL_WRITE_MASK);
		// pin in sleep with both settings of the disable bit, then in normal operation with it set
		sleep_i <= 1'b1;
		pin_watch(1'b1, 1'b0);
		wb_cycle(1'b1, A, 4'h1, 8'h85, 8'h00);
		pin_watch(1'b0, 1'b0);
		sleep_i <= 1'b0;
		pin_watch(1'b0, 1'b0);
		// software standby keeps the register, pin high
		wb_cycle(1'b1, A, 4'h1, 8'h05, 8'h00);
		// the oscillator stand-in stops while standby lasts
		sw_standby_i <= 1'b1;
		pin_watch(1'b0, 1'b0);
		sw_standby_i <= 1'b0;
		wb_cycle(1'b0, A, 4'h1, 8'h00, 8'h05);
		// hardware standby floats the pin and clears the register
		hw_standby_pin_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		check("pin float", 32'h1, {31'h0, phi_pin_oe_n_o});
		hw_standby_pin_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		check("select cleared", 32'h0, {29'h0, bm_clk_sel_o});
		wb_cycle(1'b0, A, 4'h1, 8'h00, CTRL_RESET);
		repeat (4) @(posedge clk_i);
		wrap_up;
	end
endmodule // tb
